// file: fsw_status_ctrl.sv
// serial flash status word, write-enable latch and write-protection policy
//
// Function
// - busy flag is 1 while program, erase or status write runs, else 0
// - with write latch clear, status write, program and erase are refused
// - five area guard bits written only by status write; guarded region blocks program/erase
// - area guard bits change only outside the hardware-protected lock state
// - full erase only with low three guard bits all 0/invert 0 or all 1/invert 1
// - four-lane enable 0: pins are write guard and pause; 1: data lanes
// - otp lock bits S13..S11 default 0, set one by one, never cleared
// - guard invert S14 default 0, inverts the guarded region selection
// - suspend sets erase paused S15 or program paused S10; both read-only
// - resume or power cycle clears both suspend flags
// - drive strength 00 100%, 01 75%, 10 50%, 11 25%
// - lock mode 00: status write accepted whenever write latch is 1, no operation is busy or suspended and deep power-down is off
// - lock mode 01 with write guard pin low and four-lane enable 0: status word locked
// - lock mode 01 with write guard pin high: write accepted with latch set
// - lock mode 10 refuses status writes until power cycle, which returns 00
// - lock mode 11 refuses every status write permanently
// - in deep power-down only the release instruction is obeyed
// - write enable sets latch; power-up, disable, writes, erases, reset clear it
// - four-lane read and program obeyed only with four-lane enable set
`timescale 1ns/100ps
`include "fsw_regs.svh"

module fsw_status_ctrl #(
	parameter int OP_CYCLES = `FSW_OP_CYCLES
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic            pwr_cycle,
	input  wire logic            spi_sclk,
	input  wire logic            spi_cs_n,
	input  wire logic            spi_si,
	input  wire logic            write_guard_n,
	output logic                 spi_so,
	output logic                 spi_so_oe,
	output logic [23:0]          status_word,
	output logic                 array_go,
	output fsw_pkg::fsw_op_t     array_op,
	output logic [23:0]          array_addr,
	output logic                 quad_read_go,
	output logic                 quad_lanes,
	output logic [1:0]           output_strength_sel
);

	localparam int CW = $clog2(OP_CYCLES + 1);

	if (OP_CYCLES < 1 || OP_CYCLES > 4096)
	begin : g_bad_cycles
		$error("OP_CYCLES out of range");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic fsw_guarded(input logic [23:0] a, input logic [4:0] bp, input logic cmp);
		logic [23:0] m;
		logic        hit;
		m   = 24'hFFFFFF;
		hit = 1'b0;
		if (bp[2:0] == 3'h7)
			hit = 1'b1;
		else if (bp[2:0] != 3'h0)
		begin
			// sector-sized areas saturate at 32 KB
			if (bp[4])
				m = 24'hFFFFFF << (12 + ((bp[2:0] > 3'h4) ? 3 : int'(bp[2:0]) - 1));
			else
				m = 24'hFFFFFF << (17 + int'(bp[2:0]));
			hit = bp[3] ? ((a & m) == 24'h0) : ((a & m) == m);
		end
		return hit ^ cmp;
	endfunction

	function automatic logic [7:0] fsw_byte(input logic [23:0] s, input logic [1:0] idx);
		return (idx == 2'h2) ? s[23:16] : (idx == 2'h1) ? s[15:8] : s[7:0];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                  sclk_s1, sclk_s2, sclk_q;
	logic                  cs_s1, cs_s2;
	logic                  si_s1, si_s2;
	logic                  wg_s1, wg_s2;
	fsw_pkg::fsw_frame_t   frame, next_frame;
	logic [5:0]            bit_cnt;
	logic [31:0]           shift_in;
	logic [7:0]            opcode;
	logic [23:0]           addr_q;
	logic [23:0]           status, next_status;
	logic [CW-1:0]         busy_cnt, next_busy_cnt;
	logic                  op_erase, next_op_erase;
	logic                  dpd, next_dpd;
	logic                  rst_armed, next_rst_armed;
	logic                  next_go;
	fsw_pkg::fsw_op_t      next_op;
	logic [7:0]            out_sr;
	logic [2:0]            out_cnt;
	logic [1:0]            rd_idx;
	logic                  rd_active;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire       sclk_rise = sclk_s2 & ~sclk_q;
	wire       sclk_fall = ~sclk_s2 & sclk_q;
	wire       in_sel    = (frame == fsw_pkg::FR_SEL);
	wire       end_ev    = in_sel & cs_s2;
	wire       op_strobe = in_sel & ~cs_s2 & sclk_rise & (bit_cnt == 6'd7);
	wire [7:0] in_byte   = {shift_in[6:0], si_s2};
	wire       write_in_progress_flag       = status[`FSW_WIP];
	wire       write_latch_flag       = status[`FSW_WEL];
	wire       qe        = status[`FSW_QE];
	wire       cmp       = status[`FSW_CMP];
	wire [4:0] bp        = status[`FSW_BP_HI:`FSW_BP_LO];
	wire [1:0] lock_mode = {status[`FSW_SRP1], status[`FSW_SRP0]};
	wire       sus_any   = status[`FSW_ERASE_PAUSED_FLAG] | status[`FSW_PROGRAM_PAUSED_FLAG];
	wire       len8      = (bit_cnt == 6'd8);

	// the guard pin counts only while it is not a data lane
	wire hw_locked = (lock_mode == `FSW_LOCK_HW) & ~qe & ~wg_s2;
	wire lock_ok   = (lock_mode == `FSW_LOCK_SW) | ((lock_mode == `FSW_LOCK_HW) & ~hw_locked);
	wire wr_ok     = write_latch_flag & ~write_in_progress_flag & lock_ok;
	wire ce_ok     = ((bp[2:0] == 3'h0) & ~cmp) | ((bp[2:0] == 3'h7) & cmp);
	wire addr_hit  = fsw_guarded(addr_q, bp, cmp);
	wire arr_ok    = write_latch_flag & ~write_in_progress_flag & ~sus_any & ~dpd;

	wire is_prog  = (opcode == `FSW_OP_PP) | ((opcode == `FSW_OP_QPP) & qe);
	wire is_se    = (opcode == `FSW_OP_SE);
	wire is_b32   = (opcode == `FSW_OP_BE32);
	wire is_b64   = (opcode == `FSW_OP_BE64);
	wire is_ce    = (opcode == `FSW_OP_CE1) | (opcode == `FSW_OP_CE2);
	wire go_prog  = end_ev & is_prog & (bit_cnt >= 6'd40) & arr_ok & ~addr_hit;
	wire go_erase = end_ev & (is_se | is_b32 | is_b64) & (bit_cnt == 6'd32) & arr_ok & ~addr_hit;
	wire go_chip  = end_ev & is_ce & len8 & arr_ok & ce_ok;

	wire wr1     = (opcode == `FSW_OP_WRSR1);
	wire wr2     = (opcode == `FSW_OP_WRSR2);
	wire wr3     = (opcode == `FSW_OP_WRSR3);
	wire wr_len  = (wr1 & ((bit_cnt == 6'd16) | (bit_cnt == 6'd24))) | ((wr2 | wr3) & (bit_cnt == 6'd16));
	wire wrsr_ev = end_ev & wr_len & ~dpd & ~sus_any;
	wire wrsr_go = wrsr_ev & wr_ok;

	wire [23:0] wr_data = wr3 ? {shift_in[7:0], 16'h0000}
	                    : wr2 ? {8'h00, shift_in[7:0], 8'h00}
	                    : (bit_cnt == 6'd24) ? {8'h00, shift_in[7:0], shift_in[15:8]}
	                    : {16'h0000, shift_in[7:0]};
	wire [23:0] wr_sel  = wr3 ? 24'hFF0000 : wr2 ? 24'h00FF00 : (bit_cnt == 6'd24) ? 24'h00FFFF : 24'h0000FF;
	wire [23:0] wr_mask = wr_sel & `FSW_WR_MASK;
	// otp bits can only be ORed in
	wire [23:0] written = (status & ~wr_mask) | (wr_data & wr_mask) | (status & `FSW_LB_MASK);

	wire cmd1      = end_ev & len8 & ~dpd;
	wire do_wren   = cmd1 & (opcode == `FSW_OP_WREN) & ~write_in_progress_flag;
	wire do_wrdi   = cmd1 & (opcode == `FSW_OP_WRDI);
	wire do_susp   = cmd1 & (opcode == `FSW_OP_SUSP) & write_in_progress_flag & ~sus_any;
	wire do_resume = cmd1 & (opcode == `FSW_OP_RESUME) & sus_any;
	wire do_dpd    = cmd1 & (opcode == `FSW_OP_DPD) & ~write_in_progress_flag;
	wire do_rel    = end_ev & (bit_cnt >= 6'd8) & (opcode == `FSW_OP_REL);
	wire do_rsten  = cmd1 & (opcode == `FSW_OP_RSTEN);
	wire do_rst    = cmd1 & (opcode == `FSW_OP_RST) & rst_armed;

	wire       rd_hit  = (in_byte == `FSW_OP_RDSR1) | (in_byte == `FSW_OP_RDSR2) | (in_byte == `FSW_OP_RDSR3);
	wire [1:0] rd_next = (in_byte == `FSW_OP_RDSR3) ? 2'h2 : (in_byte == `FSW_OP_RDSR2) ? 2'h1 : 2'h0;
	wire       qrd_hit = (in_byte == `FSW_OP_QOR) | (in_byte == `FSW_OP_QIOR) | (in_byte == `FSW_OP_QWR);

	// ----------------------------------------------------------------
	// link sampling and frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		{sclk_s1, sclk_s2, sclk_q} <= {spi_sclk, sclk_s1, sclk_s2};
		{cs_s1, cs_s2}             <= {spi_cs_n, cs_s1};
		{si_s1, si_s2}             <= {spi_si, si_s1};
		{wg_s1, wg_s2}             <= {write_guard_n, wg_s1};
	end

	// select only after chip select has been seen high
	always_comb
	begin
		next_frame = frame;
		case (frame)
			fsw_pkg::FR_WAIT: if (cs_s2) next_frame = fsw_pkg::FR_IDLE;
			fsw_pkg::FR_IDLE: if (!cs_s2) next_frame = fsw_pkg::FR_SEL;
			fsw_pkg::FR_SEL:  if (cs_s2) next_frame = fsw_pkg::FR_IDLE;
			default:          next_frame = fsw_pkg::FR_WAIT;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || pwr_cycle)
			frame <= fsw_pkg::FR_WAIT;
		else
			frame <= next_frame;
		if (sys_rst || !in_sel)
			bit_cnt <= 6'd0;
		else if (sclk_rise && bit_cnt != 6'd63)
			bit_cnt <= bit_cnt + 6'd1;
		if (sys_rst)
			shift_in <= 32'h0;
		else if (in_sel && sclk_rise)
			shift_in <= {shift_in[30:0], si_s2};
		if (sys_rst)
			opcode <= 8'h00;
		else if (op_strobe)
			opcode <= in_byte;
		if (sys_rst)
			addr_q <= 24'h0;
		else if (in_sel && sclk_rise && bit_cnt == 6'd31)
			addr_q <= {shift_in[22:0], si_s2};
	end

	// ----------------------------------------------------------------
	// status word update
	// ----------------------------------------------------------------
	always_comb
	begin
		next_status    = status;
		next_busy_cnt  = busy_cnt;
		next_op_erase  = op_erase;
		next_dpd       = dpd;
		next_rst_armed = end_ev ? do_rsten : rst_armed;
		next_go        = 1'b0;
		next_op        = fsw_pkg::OP_NONE;
		if (write_in_progress_flag)
		begin
			if (busy_cnt <= CW'(1))
			begin
				next_status[`FSW_WIP] = 1'b0;
				next_busy_cnt         = '0;
			end
			else
				next_busy_cnt = busy_cnt - CW'(1);
		end
		if (wrsr_go)
			next_status = written;
		if (go_prog || go_erase || go_chip || wrsr_go)
		begin
			next_status[`FSW_WEL] = 1'b0;
			next_status[`FSW_WIP] = 1'b1;
			next_busy_cnt         = CW'(OP_CYCLES);
			next_op_erase         = ~go_prog & ~wrsr_go;
			next_go               = ~wrsr_go;
			// a status write starts no array work, so the op code stays idle
			next_op               = wrsr_go ? fsw_pkg::OP_NONE
			                      : go_prog ? fsw_pkg::OP_PROG : go_chip ? fsw_pkg::OP_CHIP
			                      : is_se ? fsw_pkg::OP_SECT : is_b32 ? fsw_pkg::OP_BLK32 : fsw_pkg::OP_BLK64;
		end
		if (do_wren)
			next_status[`FSW_WEL] = 1'b1;
		if (do_wrdi || do_rst)
			next_status[`FSW_WEL] = 1'b0;
		if (do_susp)
		begin
			next_status[`FSW_ERASE_PAUSED_FLAG] = op_erase;
			next_status[`FSW_PROGRAM_PAUSED_FLAG] = ~op_erase;
			next_status[`FSW_WIP]  = 1'b0;
			next_go                = 1'b1;
			next_op                = fsw_pkg::OP_SUSP;
		end
		if (do_resume)
		begin
			next_status[`FSW_ERASE_PAUSED_FLAG] = 1'b0;
			next_status[`FSW_PROGRAM_PAUSED_FLAG] = 1'b0;
			next_status[`FSW_WIP]  = 1'b1;
			next_go                = 1'b1;
			next_op                = fsw_pkg::OP_RESUME;
		end
		if (do_dpd)
			next_dpd = 1'b1;
		if (do_rel)
			next_dpd = 1'b0;
		if (pwr_cycle)
		begin
			// nonvolatile fields survive, except lock mode 10, which returns to 00; volatile state restarts
			next_status[`FSW_WEL]  = 1'b0;
			next_status[`FSW_WIP]  = 1'b0;
			next_status[`FSW_ERASE_PAUSED_FLAG] = 1'b0;
			next_status[`FSW_PROGRAM_PAUSED_FLAG] = 1'b0;
			if (lock_mode == `FSW_LOCK_PWR)
			begin
				next_status[`FSW_SRP1] = 1'b0;
				next_status[`FSW_SRP0] = 1'b0;
			end
			next_busy_cnt  = '0;
			next_dpd       = 1'b0;
			next_rst_armed = 1'b0;
			next_go        = 1'b0;
			next_op        = fsw_pkg::OP_NONE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status       <= `FSW_STATUS_RST;
			busy_cnt     <= '0;
			op_erase     <= 1'b0;
			dpd          <= 1'b0;
			rst_armed    <= 1'b0;
			array_go     <= 1'b0;
			array_op     <= fsw_pkg::OP_NONE;
			array_addr   <= 24'h0;
			quad_read_go <= 1'b0;
		end
		else
		begin
			status       <= next_status;
			busy_cnt     <= next_busy_cnt;
			op_erase     <= next_op_erase;
			dpd          <= next_dpd;
			rst_armed    <= next_rst_armed;
			array_go     <= next_go;
			array_op     <= next_op;
			array_addr   <= addr_q;
			quad_read_go <= op_strobe & qrd_hit & qe & ~dpd;
		end
	end

	assign status_word         = status;
	assign quad_lanes          = status[`FSW_QE];
	assign output_strength_sel = status[`FSW_DRV_HI:`FSW_DRV_LO];

	// ----------------------------------------------------------------
	// status readout, repeats the live byte until deselect
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst || !in_sel || cs_s2)
		begin
			rd_active <= 1'b0;
			spi_so_oe <= 1'b0;
			spi_so    <= 1'b0;
			out_sr    <= 8'h00;
			out_cnt   <= 3'h0;
			rd_idx    <= 2'h0;
		end
		else if (op_strobe)
		begin
			rd_active <= rd_hit & ~dpd;
			rd_idx    <= rd_next;
			out_sr    <= fsw_byte(status, rd_next);
			out_cnt   <= 3'h0;
		end
		else if (sclk_fall && rd_active)
		begin
			spi_so    <= out_sr[7];
			spi_so_oe <= 1'b1;
			out_sr    <= (out_cnt == 3'h7) ? fsw_byte(status, rd_idx) : {out_sr[6:0], 1'b0};
			out_cnt   <= out_cnt + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	wire go_wr = array_go && array_op != fsw_pkg::OP_SUSP && array_op != fsw_pkg::OP_RESUME;

	property p_busy_on_go;
		go_wr |-> status[`FSW_WIP] ##1 (status[`FSW_WIP] || pwr_cycle || $past(do_susp));
	endproperty
	a_busy_on_go: assert property (p_busy_on_go) else $error("busy flag not raised by array start");

	property p_go_needs_wel;
		go_wr |-> $past(status[`FSW_WEL]) && !status[`FSW_WEL];
	endproperty
	a_go_needs_wel: assert property (p_go_needs_wel) else $error("array start without write latch");

	property p_guard;
		go_wr && array_op != fsw_pkg::OP_CHIP |-> !fsw_guarded(array_addr, status[6:2], status[`FSW_CMP]);
	endproperty
	a_guard: assert property (p_guard) else $error("program or erase inside guarded region");

	property p_hw_lock;
		hw_locked && !pwr_cycle |=> $stable(status[`FSW_BP_HI:`FSW_BP_LO]);
	endproperty
	a_hw_lock: assert property (p_hw_lock) else $error("guard bits changed while hardware locked");

	property p_chip_gate;
		go_wr && array_op == fsw_pkg::OP_CHIP |-> ce_ok;
	endproperty
	a_chip_gate: assert property (p_chip_gate) else $error("full erase with guard bits set");

	property p_otp_sticky;
		(($past(status) & ~status) & `FSW_LB_MASK) == 24'h0;
	endproperty
	a_otp_sticky: assert property (p_otp_sticky) else $error("otp lock bit cleared");

	property p_resume;
		array_go && array_op == fsw_pkg::OP_RESUME |-> !status[`FSW_ERASE_PAUSED_FLAG] && !status[`FSW_PROGRAM_PAUSED_FLAG] && status[`FSW_WIP];
	endproperty
	a_resume: assert property (p_resume) else $error("suspend flags left after resume");

	property p_pwr_unlock;
		pwr_cycle && lock_mode == `FSW_LOCK_PWR |=> lock_mode == `FSW_LOCK_SW;
	endproperty
	a_pwr_unlock: assert property (p_pwr_unlock) else $error("power lock not released by power cycle");

	property p_otp_mode;
		lock_mode == 2'h3 |=> $stable(status & `FSW_WR_MASK);
	endproperty
	a_otp_mode: assert property (p_otp_mode) else $error("status changed in permanent lock");

	property p_dpd_ignore;
		dpd && end_ev && opcode != `FSW_OP_REL && !pwr_cycle |=> $stable(status) && dpd;
	endproperty
	a_dpd_ignore: assert property (p_dpd_ignore) else $error("instruction obeyed in deep power-down");

	property p_refused_write;
		wrsr_ev && !wr_ok && !pwr_cycle |=> $stable(status & `FSW_WR_MASK) && $stable(status[`FSW_WEL]);
	endproperty
	a_refused_write: assert property (p_refused_write) else $error("refused status write changed bits");

	c_chip_erase: cover property (go_wr && array_op == fsw_pkg::OP_CHIP);
	c_suspend:    cover property (array_go && array_op == fsw_pkg::OP_SUSP);
	c_wrsr:       cover property (wrsr_go);
	c_read:       cover property (rd_active && spi_so_oe);

endmodule // fsw_status_ctrl

// file: fsw_regs.svh
// status and control word layout, instruction codes and timing counts
`ifndef FSW_REGS_SVH
`define FSW_REGS_SVH

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define FSW_WIP          0
`define FSW_WEL          1
`define FSW_BP_LO        2
`define FSW_BP_HI        6
`define FSW_SRP0         7
`define FSW_SRP1         8
`define FSW_QE           9
`define FSW_PROGRAM_PAUSED_FLAG         10
`define FSW_LB_LO        11
`define FSW_LB_HI        13
`define FSW_CMP          14
`define FSW_ERASE_PAUSED_FLAG         15
`define FSW_DRV_LO       21
`define FSW_DRV_HI       22

// ----------------------------------------------------------------
// reset value and write masks
// ----------------------------------------------------------------
`define FSW_STATUS_RST   24'h000000
`define FSW_WR_MASK      24'h607BFC
`define FSW_LB_MASK      24'h003800
`define FSW_LOCK_SW      2'h0
`define FSW_LOCK_HW      2'h1
`define FSW_LOCK_PWR     2'h2

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define FSW_OP_WREN      8'h06
`define FSW_OP_WRDI      8'h04
`define FSW_OP_RDSR1     8'h05
`define FSW_OP_RDSR2     8'h35
`define FSW_OP_RDSR3     8'h15
`define FSW_OP_WRSR1     8'h01
`define FSW_OP_WRSR2     8'h31
`define FSW_OP_WRSR3     8'h11
`define FSW_OP_PP        8'h02
`define FSW_OP_QPP       8'h32
`define FSW_OP_SE        8'h20
`define FSW_OP_BE32      8'h52
`define FSW_OP_BE64      8'hD8
`define FSW_OP_CE1       8'hC7
`define FSW_OP_CE2       8'h60
`define FSW_OP_SUSP      8'h75
`define FSW_OP_RESUME    8'h7A
`define FSW_OP_DPD       8'hB9
`define FSW_OP_REL       8'hAB
`define FSW_OP_RSTEN     8'h66
`define FSW_OP_RST       8'h99
`define FSW_OP_QOR       8'h6B
`define FSW_OP_QIOR      8'hEB
`define FSW_OP_QWR       8'hE7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSW_OP_CYCLES    200

`endif

// file: fsw_pkg.sv
// types shared by the status and write-protect logic
package fsw_pkg;
	typedef enum logic [1:0] {FR_WAIT, FR_IDLE, FR_SEL} fsw_frame_t;
	typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP, OP_SUSP, OP_RESUME} fsw_op_t;
endpackage

// file: fsw_host_model.sv
// serial host model that issues flash instructions in mode 0
`timescale 1ns/100ps

module fsw_host_model (
	input  wire logic clk,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so,
	input  wire logic spi_so_oe
);
	logic [39:0] rx;
	logic        oe_last;
	int          gap;

	initial
	begin
		spi_sclk = 1'h0;
		spi_cs_n = 1'h1;
		spi_si   = 1'h0;
		gap      = 8;
	end

	// ----------------------------------------------------------------
	// one frame, msb first, tx left aligned
	// ----------------------------------------------------------------
	task automatic frame(input logic [39:0] tx, input int nbits);
		rx = '0;
		@(negedge clk);
		spi_cs_n = 1'h0;
		for (int i = 0; i < nbits; i++)
		begin
			spi_si = tx[39 - i];
			#160 spi_sclk = 1'h1;
			// late in the high phase, so the device output has settled
			#150 rx = {rx[38:0], spi_so};
			oe_last = spi_so_oe;
			#10 spi_sclk = 1'h0;
		end
		#160 spi_cs_n = 1'h1;
		// released line must not keep showing its last bit
		spi_si = ~spi_si;
		repeat (gap) @(negedge clk);
	endtask
endmodule // fsw_host_model

// file: fsw_status_ctrl_tb.sv
// self-checking bench for the status word and write-protect logic
`timescale 1ns/100ps
`include "fsw_regs.svh"

module fsw_status_ctrl_tb;
	logic             clk;
	logic             sys_rst;
	logic             pwr_cycle;
	logic             write_guard_n;
	wire logic        spi_sclk;
	wire logic        spi_cs_n;
	wire logic        spi_si;
	logic             spi_so;
	logic             spi_so_oe;
	logic [23:0]      status_word;
	logic             array_go;
	fsw_pkg::fsw_op_t array_op;
	logic [23:0]      array_addr;
	logic             quad_read_go;
	logic             quad_lanes;
	logic [1:0]       output_strength_sel;
	logic [23:0]      go_cnt;
	logic [23:0]      q_cnt;
	fsw_pkg::fsw_op_t last_op;
	logic [23:0]      last_addr;
	int               err_count;
	int               comparisons;

	fsw_status_ctrl #(.OP_CYCLES(120)) DUT (.clk(clk), .sys_rst(sys_rst), .pwr_cycle(pwr_cycle),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .write_guard_n(write_guard_n),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .status_word(status_word), .array_go(array_go),
		.array_op(array_op), .array_addr(array_addr), .quad_read_go(quad_read_go),
		.quad_lanes(quad_lanes), .output_strength_sel(output_strength_sel));
	fsw_host_model host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe));

	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (array_go === 1'h1)
		begin
			go_cnt    <= go_cnt + 24'h1;
			last_op   <= array_op;
			last_addr <= array_addr;
		end
		if (quad_read_go === 1'h1)
			q_cnt <= q_cnt + 24'h1;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		host.frame({op, 32'h0}, 8);
	endtask
	task automatic settle;
		int n;
		n = 0;
		while (status_word[0] !== 1'h0 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		chk(24'(status_word[0]), 24'h0, "busy stuck");
	endtask
	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_WRSR1, lo, hi, 16'h0}, 24);
		settle();
	endtask
	task automatic power;
		@(negedge clk);
		pwr_cycle = 1'h1;
		@(negedge clk);
		pwr_cycle = 1'h0;
		repeat (8) @(negedge clk);
	endtask
	task automatic se(input logic [23:0] a, input logic ok);
		logic [23:0] c;
		c = go_cnt;
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_SE, a, 8'h0}, 32);
		settle();
		chk(go_cnt - c, 24'(ok), "sector erase");
		if (ok)
		begin
			chk(last_addr, a, "erase addr");
			chk(24'(last_op), 24'(fsw_pkg::OP_SECT), "erase op");
		end
	endtask
	task automatic pp;
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_PP, 24'h000100, 8'hA5}, 40);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_latch;
		chk(status_word, 24'h0, "reset word");
		chk({21'h0, quad_lanes, output_strength_sel}, 24'h0, "reset pins");
		host.frame({`FSW_OP_WRSR1, 8'h1C, 24'h0}, 24);
		chk(status_word, 24'h0, "write without latch");
		cmd(`FSW_OP_WREN);
		chk(status_word, 24'h000002, "latch set");
		host.frame({`FSW_OP_RDSR1, 32'h0}, 16);
		chk({16'h0, host.rx[7:0]}, 24'h000002, "serial read");
		chk(24'(host.oe_last), 24'h1, "read enable");
		cmd(`FSW_OP_WRDI);
		chk(status_word, 24'h0, "latch off");
		cmd(`FSW_OP_WREN);
		cmd(`FSW_OP_RSTEN);
		cmd(`FSW_OP_RST);
		chk(status_word, 24'h0, "soft reset");
		pp();
		chk(24'(status_word[1:0]), 24'h1, "program busy");
		settle();
		$display("latch test done");
	endtask

	task automatic t_erase;
		logic [7:0]  lo [4];
		logic [7:0]  hi [4];
		logic [23:0] c;
		lo = '{8'h00, 8'h1C, 8'h1C, 8'h00};
		hi = '{8'h00, 8'h00, 8'h40, 8'h40};
		for (int i = 0; i < 4; i++)
		begin
			wrsr(lo[i], hi[i]);
			chk(24'(status_word[14]), 24'(hi[i][6]), "invert bit");
			c = go_cnt;
			cmd(`FSW_OP_WREN);
			cmd(`FSW_OP_CE1);
			settle();
			chk(go_cnt - c, 24'((lo[i] == 8'h1C) == (hi[i] == 8'h40)), "full erase");
		end
		chk(24'(last_op), 24'(fsw_pkg::OP_CHIP), "full erase op");
		wrsr(8'h04, 8'h00);
		se(24'hFFF000, 1'h0);
		se(24'h001000, 1'h1);
		wrsr(8'h04, 8'h40);
		se(24'h001000, 1'h0);
		se(24'hFFF000, 1'h1);
		$display("erase test done");
	endtask

	task automatic t_suspend;
		wrsr(8'h00, 8'h00);
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_SE, 32'h0}, 32);
		cmd(`FSW_OP_SUSP);
		chk(status_word & 24'h008401, 24'h008000, "erase paused");
		chk(24'(last_op), 24'(fsw_pkg::OP_SUSP), "suspend op");
		cmd(`FSW_OP_RESUME);
		chk(status_word & 24'h008401, 24'h000001, "erase resumed");
		chk(24'(last_op), 24'(fsw_pkg::OP_RESUME), "resume op");
		settle();
		pp();
		cmd(`FSW_OP_SUSP);
		chk(status_word & 24'h008401, 24'h000400, "program paused");
		power();
		chk(status_word & 24'h008403, 24'h0, "power clears");
		$display("suspend test done");
	endtask

	task automatic t_strength;
		logic [1:0] lv;
		for (int v = 0; v < 4; v++)
		begin
			lv = v[1:0];
			cmd(`FSW_OP_WREN);
			host.frame({`FSW_OP_WRSR3, 1'h0, lv, 5'h0, 24'h0}, 16);
			settle();
			chk(24'(output_strength_sel), 24'(lv), "strength");
			chk(24'(status_word[22:21]), 24'(lv), "strength bits");
		end
		host.frame({`FSW_OP_RDSR3, 32'h0}, 16);
		chk({16'h0, host.rx[7:0]}, 24'h000060, "third byte read");
		$display("strength test done");
	endtask

	task automatic t_quad;
		logic [23:0] c;
		c = q_cnt;
		host.frame({`FSW_OP_QOR, 32'h0}, 32);
		chk(q_cnt - c, 24'h0, "quad read off");
		// guard pin is driven, never tied, while lanes are enabled
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_WRSR2, 8'h02, 24'h0}, 16);
		settle();
		chk(24'(quad_lanes), 24'h1, "lanes on");
		host.frame({`FSW_OP_QOR, 32'h0}, 32);
		chk(q_cnt - c, 24'h1, "quad read on");
		cmd(`FSW_OP_WREN);
		host.frame({`FSW_OP_WRSR2, 32'h0}, 16);
		settle();
		chk(24'(quad_lanes), 24'h0, "lanes off");
		$display("quad test done");
	endtask

	task automatic t_sleep;
		cmd(`FSW_OP_DPD);
		cmd(`FSW_OP_WREN);
		chk(24'(status_word[1]), 24'h0, "asleep");
		host.gap = 40;
		cmd(`FSW_OP_REL);
		host.gap = 8;
		cmd(`FSW_OP_WREN);
		chk(24'(status_word[1]), 24'h1, "awake");
		cmd(`FSW_OP_WRDI);
		$display("sleep test done");
	endtask

	task automatic t_otp;
		wrsr(8'h00, 8'h08);
		chk(24'(status_word[13:11]), 24'h1, "otp one");
		wrsr(8'h00, 8'h10);
		chk(24'(status_word[13:11]), 24'h3, "otp two");
		wrsr(8'h00, 8'h00);
		chk(24'(status_word[13:11]), 24'h3, "otp kept");
		$display("otp test done");
	endtask

	task automatic t_lock;
		write_guard_n = 1'h0;
		wrsr(8'h04, 8'h00);
		chk(status_word & 24'h0001FF, 24'h000004, "soft mode");
		wrsr(8'h80, 8'h00);
		wrsr(8'h1C, 8'h00);
		chk(status_word & 24'h0001FF, 24'h000082, "pin locked");
		write_guard_n = 1'h1;
		wrsr(8'h9C, 8'h00);
		chk(status_word & 24'h0001FF, 24'h00009C, "pin open");
		wrsr(8'h00, 8'h01);
		wrsr(8'h1C, 8'h00);
		chk(status_word & 24'h0001FF, 24'h000102, "supply lock");
		power();
		chk(status_word & 24'h0001FF, 24'h0, "lock released");
		wrsr(8'h80, 8'h01);
		power();
		wrsr(8'h1C, 8'h00);
		chk(status_word & 24'h0001FF, 24'h000182, "permanent");
		$display("lock test done");
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		sys_rst       = 1'h1;
		pwr_cycle     = 1'h0;
		write_guard_n = 1'h1;
		go_cnt        = '0;
		q_cnt         = '0;
		last_op       = fsw_pkg::OP_NONE;
		last_addr     = '0;
		err_count     = 0;
		comparisons   = 0;
		repeat (5) @(negedge clk);
		sys_rst = 1'h0;
		repeat (8) @(negedge clk);
		t_latch();
		t_erase();
		t_suspend();
		t_strength();
		t_quad();
		t_sleep();
		t_otp();
		t_lock();
		summarize();
	end

	initial
	begin
		#3000000;
		err_count++;
		summarize();
	end
endmodule // fsw_status_ctrl_tb
